// ===== hw/led_pwr_pkg.sv
// Behaviour
// - Shared indicator pins are sampled as configuration at reset release, then drive status.
// - Standard scheme: sampled low gives an active-high driver; sampled high gives an active-low driver.
// - Standard scheme: all off without link; link, one speed pair output and, at full duplex, duplex lit.
// - Standard scheme: transmit and receive toggle; collision toggles all three in half duplex only; end off.
// - Standard scheme with active-low drivers: on is low pin, off is high pin.
// - Advanced scheme: four mode outputs, only the linked mode lit, none without link.
// - Advanced scheme: half-duplex output flashes on receive and transmit activity.
// - Advanced scheme: full-duplex output flashes on receive activity only.
// - Advanced scheme: active output is a high pin, inactive a low pin.
// - Power down the ten path at 100 Mbps and the hundred path at 10 Mbps.
// - Power-down control bit 11 disables everything except management access.
// - No link partner energy for 4 seconds reduces drive to link pulses only.
// - Any line energy while unplugged restores full transmit and receive at once.
// - Idle-wire bit 0 set stops the receive clock while only idles arrive.
// - Receive clock restarts exactly one cycle before receive data valid rises.
// - Receive clock stops again 64 cycles after data valid falls, if only idles follow.
package led_pwr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 20_000_000;
  localparam int CYC_PER_MS       = CLK_HZ / 1000;
  localparam int UNPLUG_TIME_MS   = 4000;
  localparam int UNPLUG_CYCLES    = UNPLUG_TIME_MS * CYC_PER_MS;
  localparam int BLINK_TIME_MS    = 50;
  localparam int BLINK_CYCLES     = BLINK_TIME_MS * CYC_PER_MS;
  localparam int IDLE_TAIL_CYCLES = 64;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] MISC_OFFSET    = 12'h004;
  localparam logic [11:0] STATUS_OFFSET  = 12'h008;
  localparam logic [11:0] STRAP_OFFSET   = 12'h00C;
  localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
  localparam logic [31:0] MISC_RESET     = 32'h0000_0000;
  localparam int          POWER_DOWN_BIT = 11;
  localparam int          IDLE_WIRE_BIT  = 0;
  localparam int          ADV_SCHEME_BIT = 1;
  localparam int          ST_LINK_BIT    = 0;
  localparam int          ST_SPEED_BIT   = 1;
  localparam int          ST_DUPLEX_BIT  = 2;
  localparam int          ST_UNPLUG_BIT  = 3;
  localparam int          ST_RXCLK_BIT   = 4;
  localparam int          ST_STRAP_BIT   = 5;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // Shared indicator pins
  // ----------------------------------------------------------------
  localparam int NUM_LED_PINS = 7;
  localparam int NUM_BLINKERS = 4;

  typedef struct packed {
    logic link;
    logic speed_100;
    logic full_duplex;
  } port_status_s;

  typedef struct packed {
    logic tx;
    logic rx;
    logic col;
  } activity_s;

  typedef enum logic [1:0] {
    RXC_RUN  = 2'b00,
    RXC_TAIL = 2'b01,
    RXC_STOP = 2'b10
  } rxclk_state_e;

endpackage

// ===== hw/led_blinker.sv
`timescale 1ns/1ps
// Toggles on each tick while activity was seen, otherwise rests off
module led_blinker (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic tick,
  input  wire logic activity,
  output logic      blink
);

  logic seen;

  // Activity arriving on the tick itself is kept for the next period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen  <= 1'b0;
      blink <= 1'b0;
    end else begin
      seen <= activity | (seen & ~tick);
      if (tick) begin
        blink <= (seen | activity) ? ~blink : 1'b0;
      end
    end
  end

endmodule

// ===== hw/led_power_ctrl.sv
`timescale 1ns/1ps
module led_power_ctrl #(
  parameter int UNPLUG_LIMIT = led_pwr_pkg::UNPLUG_CYCLES,
  parameter int BLINK_LIMIT  = led_pwr_pkg::BLINK_CYCLES,
  parameter int TAIL_LIMIT   = led_pwr_pkg::IDLE_TAIL_CYCLES
) (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  // AXI4-Lite slave
  input  wire logic [led_pwr_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [led_pwr_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // Port state from the transceiver core
  input  wire led_pwr_pkg::port_status_s        port_status,
  input  wire led_pwr_pkg::activity_s           activity,
  input  wire logic                             rx_dv_core,
  input  wire logic                             rx_idle_core,
  input  wire logic                             line_energy,
  // Shared indicator and configuration pins
  input  wire logic [led_pwr_pkg::NUM_LED_PINS-1:0] led_pin_in,
  output logic [led_pwr_pkg::NUM_LED_PINS-1:0]      led_pin_out,
  output logic [led_pwr_pkg::NUM_LED_PINS-1:0]      led_pin_oe,
  // Power and receive clock controls
  output logic                                  ten_path_en,
  output logic                                  hundred_path_en,
  output logic                                  tx_full_drive,
  output logic                                  link_pulse_only,
  output logic                                  core_enable,
  output logic                                  rx_clk_en,
  output logic                                  rx_dv
);

  import led_pwr_pkg::*;

  localparam int UNP_W  = $clog2(UNPLUG_LIMIT + 1);
  localparam int BLK_W  = $clog2(BLINK_LIMIT + 1);
  localparam int TAIL_W = $clog2(TAIL_LIMIT + 1);

  // Counters need at least one cycle, the tail counter two, to mean anything
  if (UNPLUG_LIMIT < 1 || BLINK_LIMIT < 1 || TAIL_LIMIT < 2) begin : g_bad_param
    $error("led_power_ctrl: timing parameters out of range");
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0]       control;
  logic [31:0]       misc;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              unplugged;
  logic              strap_done;
  logic [NUM_LED_PINS-1:0] active_low;

  wire aw_hs     = s_axi_awvalid & s_axi_awready;
  wire w_hs      = s_axi_wvalid & s_axi_wready;
  wire ar_hs     = s_axi_arvalid & s_axi_arready;
  wire wr_go     = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wr_ctrl   = wr_go & (wr_addr == CONTROL_OFFSET);
  wire wr_misc   = wr_go & (wr_addr == MISC_OFFSET);
  wire wr_ok     = wr_ctrl | wr_misc |
                   (wr_addr == STATUS_OFFSET) | (wr_addr == STRAP_OFFSET);
  wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                           {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  wire power_down  = control[POWER_DOWN_BIT];
  wire idle_wire   = misc[IDLE_WIRE_BIT];
  wire adv_scheme  = misc[ADV_SCHEME_BIT];

  // Read mux; status word reflects live block state
  wire [31:0] status_word = {26'h0, strap_done, rx_clk_en, unplugged,
                             port_status.full_duplex, port_status.speed_100,
                             port_status.link};
  wire rd_ctrl = (s_axi_araddr == CONTROL_OFFSET);
  wire rd_misc = (s_axi_araddr == MISC_OFFSET);
  wire rd_stat = (s_axi_araddr == STATUS_OFFSET);
  wire rd_strp = (s_axi_araddr == STRAP_OFFSET);
  wire rd_ok   = rd_ctrl | rd_misc | rd_stat | rd_strp;
  wire [31:0] rd_word = rd_ctrl ? control :
                        rd_misc ? misc :
                        rd_stat ? status_word :
                        rd_strp ? {25'h0, active_low} : 32'h0000_0000;

  // Write address and data are taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wr_addr       <= '0;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        wr_addr       <= s_axi_awaddr;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control registers; management stays reachable in power-down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control <= CONTROL_RESET;
      misc    <= MISC_RESET;
    end else begin
      if (wr_ctrl) begin
        control <= (control & ~strb_mask) | (wr_data & strb_mask);
      end
      if (wr_misc) begin
        misc <= (misc & ~strb_mask) | (wr_data & strb_mask);
      end
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_LED_PINS-1:0] pin_meta;
  logic [NUM_LED_PINS-1:0] pin_sync;
  logic                    energy_meta;
  logic                    energy_sync;

  // Left without reset so the strap level is already settled at release
  always_ff @(posedge aclk) begin
    pin_meta    <= led_pin_in;
    pin_sync    <= pin_meta;
    energy_meta <= line_energy;
    energy_sync <= energy_meta;
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Pins are not driven until the strap is taken in the first cycle out of reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_done <= 1'b0;
      active_low <= '0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      active_low <= pin_sync;
    end
  end

  // ----------------------------------------------------------------
  // Blink timebase and toggling indicators
  // ----------------------------------------------------------------
  logic [BLK_W-1:0]        blink_cnt;
  logic                    blink_tick;
  logic [NUM_BLINKERS-1:0] blink;

  // Free running divider; a visible rate matters more than precision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt  <= '0;
      blink_tick <= 1'b0;
    end else if (blink_cnt == BLK_W'(BLINK_LIMIT - 1)) begin
      blink_cnt  <= '0;
      blink_tick <= 1'b1;
    end else begin
      blink_cnt  <= blink_cnt + 1'b1;
      blink_tick <= 1'b0;
    end
  end

  // Activity gated by link and power; collisions only count in half duplex
  wire linked  = port_status.link & ~power_down;
  wire s100    = port_status.speed_100;
  wire fdx     = port_status.full_duplex;
  wire col_hd  = linked & activity.col & ~fdx;
  wire tx_any  = linked & (activity.tx | col_hd);
  wire rx_any  = linked & (activity.rx | col_hd);
  wire adv_act = linked & (fdx ? activity.rx
                               : (activity.rx | activity.tx));
  wire [NUM_BLINKERS-1:0] blink_src = {adv_act, col_hd, rx_any, tx_any};

  for (genvar i = 0; i < NUM_BLINKERS; i++) begin : g_blink
    led_blinker u_blinker (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .tick     (blink_tick),
      .activity (blink_src[i]),
      .blink    (blink[i])
    );
  end

  // ----------------------------------------------------------------
  // Indicator mapping
  // ----------------------------------------------------------------
  // Standard order: speed pair 0/1, link, duplex, transmit, receive, collision
  wire [1:0] speed_pair_indicator = {linked & ~s100, linked & s100};
  wire       link_indicator       = linked;
  wire       duplex_indicator     = linked & fdx;
  wire       transmit_indicator   = linked & blink[0];
  wire       receive_indicator    = linked & blink[1];
  wire       collision_indicator  = linked & blink[2];
  wire [NUM_LED_PINS-1:0] std_on = {collision_indicator, receive_indicator,
                                    transmit_indicator, duplex_indicator,
                                    link_indicator, speed_pair_indicator};

  // Advanced: one output per linked mode, flashing off on activity
  wire ten_half_indicator     = linked & ~s100 & ~fdx & ~blink[3];
  wire ten_full_indicator     = linked & ~s100 & fdx & ~blink[3];
  wire hundred_half_indicator = linked & s100 & ~fdx & ~blink[3];
  wire hundred_full_indicator = linked & s100 & fdx & ~blink[3];
  wire [NUM_LED_PINS-1:0] adv_on = {3'b000, hundred_full_indicator,
                                    hundred_half_indicator, ten_full_indicator,
                                    ten_half_indicator};

  // Standard follows the strapped polarity; advanced always drives active high
  wire [NUM_LED_PINS-1:0] std_level = std_on ^ active_low;
  wire [NUM_LED_PINS-1:0] next_level = adv_scheme ? adv_on : std_level;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_pin_out <= '0;
      led_pin_oe  <= '0;
    end else begin
      led_pin_out <= strap_done ? next_level : '0;
      led_pin_oe  <= {NUM_LED_PINS{strap_done}};
    end
  end

  // ----------------------------------------------------------------
  // Unplugged detection
  // ----------------------------------------------------------------
  logic [UNP_W-1:0] unplug_cnt;

  // Energy clears at once; silence must last the whole window to set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unplug_cnt <= '0;
      unplugged  <= 1'b0;
    end else if (energy_sync) begin
      unplug_cnt <= '0;
      unplugged  <= 1'b0;
    end else if (unplug_cnt == UNP_W'(UNPLUG_LIMIT - 1)) begin
      unplugged  <= 1'b1;
    end else begin
      unplug_cnt <= unplug_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power path controls
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ten_path_en     <= 1'b0;
      hundred_path_en <= 1'b0;
      tx_full_drive   <= 1'b0;
      link_pulse_only <= 1'b0;
      core_enable     <= 1'b0;
    end else begin
      ten_path_en     <= ~power_down & ~s100;
      hundred_path_en <= ~power_down & s100;
      tx_full_drive   <= ~power_down & ~unplugged;
      link_pulse_only <= ~power_down & unplugged;
      core_enable     <= ~power_down;
    end
  end

  // ----------------------------------------------------------------
  // Idle-wire receive clock gate
  // ----------------------------------------------------------------
  rxclk_state_e      rxc_state;
  rxclk_state_e      next_rxc_state;
  logic [TAIL_W-1:0] tail_cnt;
  logic              dv_d1;

  // Quiet means no frame anywhere in the two-stage valid pipe, idles only
  wire quiet     = rx_idle_core & ~rx_dv_core & ~dv_d1 & ~rx_dv;
  wire tail_done = (tail_cnt == TAIL_W'(TAIL_LIMIT - 1));

  always_comb begin
    next_rxc_state = rxc_state;
    case (rxc_state)
      RXC_RUN: begin
        if (idle_wire && quiet) begin
          next_rxc_state = RXC_TAIL;
        end
      end
      RXC_TAIL: begin
        if (!idle_wire || !quiet) begin
          next_rxc_state = RXC_RUN;
        end else if (tail_done) begin
          next_rxc_state = RXC_STOP;
        end
      end
      RXC_STOP: begin
        if (!idle_wire || !quiet) begin
          next_rxc_state = RXC_RUN;
        end
      end
      default: begin
        next_rxc_state = RXC_RUN;
      end
    endcase
  end

  // Valid is delayed two cycles so the clock can lead it by exactly one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxc_state <= RXC_RUN;
      tail_cnt  <= '0;
      dv_d1     <= 1'b0;
      rx_dv     <= 1'b0;
      rx_clk_en <= 1'b0;
    end else begin
      rxc_state <= next_rxc_state;
      tail_cnt  <= (next_rxc_state == RXC_TAIL) ? tail_cnt + 1'b1 : '0;
      dv_d1     <= rx_dv_core & ~power_down;
      rx_dv     <= dv_d1 & ~power_down;
      rx_clk_en <= ~power_down & (next_rxc_state != RXC_STOP);
    end
  end

endmodule

// ===== verif/led_power_ctrl_properties.sv
`timescale 1ns/1ps
module led_power_ctrl_properties #(
  parameter int UNPLUG_LIMIT = led_pwr_pkg::UNPLUG_CYCLES
) (
  input logic                                 aclk,
  input logic                                 aresetn,
  input logic                                 s_axi_bvalid,
  input logic                                 s_axi_bready,
  input logic [1:0]                           s_axi_bresp,
  input led_pwr_pkg::port_status_s            port_status,
  input logic                                 rx_dv_core,
  input logic                                 line_energy,
  input logic [led_pwr_pkg::NUM_LED_PINS-1:0] led_pin_oe,
  input logic                                 ten_path_en,
  input logic                                 hundred_path_en,
  input logic                                 link_pulse_only,
  input logic                                 core_enable,
  input logic                                 rx_clk_en,
  input logic                                 rx_dv
);
  import led_pwr_pkg::*;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ------------------
  // Properties
  // ------------------
  // Raw quiet count, runs ahead of the synchroniser
  logic [31:0] quiet_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || line_energy) begin
      quiet_cnt <= '0;
    end else if (quiet_cnt < 32'(UNPLUG_LIMIT)) begin
      quiet_cnt <= quiet_cnt + 32'h1;
    end
  end

  sequence s_release;
    $rose(aresetn) ##2 1'b1;
  endsequence
  sequence s_frame_end;
    $fell(rx_dv) ##0 core_enable;
  endsequence

  a_pins_driven: assert property (s_release |-> (&led_pin_oe) [*3])
    else $error("pins not driven");
  a_hundred_path: assert property (hundred_path_en |-> $past(port_status.speed_100))
    else $error("hundred path at ten");
  a_ten_path: assert property (ten_path_en |-> !$past(port_status.speed_100))
    else $error("ten path at hundred");
  a_pd_quiet: assert property (!core_enable [*3] |-> !rx_clk_en && !rx_dv)
    else $error("receive alive in power-down");
  a_unplug_time: assert property ($rose(link_pulse_only) |-> quiet_cnt >= 32'(UNPLUG_LIMIT))
    else $error("drive cut early");
  a_energy_wake: assert property (line_energy [*6] |-> !link_pulse_only)
    else $error("drive not restored");
  a_dv_clk: assert property (rx_dv |-> rx_clk_en)
    else $error("valid without clock");
  a_dv_lag: assert property (rx_dv |-> $past(rx_dv_core, 2))
    else $error("valid without core frame");
  a_clk_lead: assert property ($rose(rx_dv) |-> $past(rx_clk_en))
    else $error("no clock lead");
  a_tail_hold: assert property (s_frame_end |-> rx_clk_en [*8])
    else $error("clock stopped in tail");
  a_b_stable: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("response dropped");
endmodule

bind led_power_ctrl led_power_ctrl_properties #(.UNPLUG_LIMIT(UNPLUG_LIMIT)) i_props (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .port_status, .rx_dv_core,
  .line_energy, .led_pin_oe, .ten_path_en, .hundred_path_en, .link_pulse_only, .core_enable,
  .rx_clk_en, .rx_dv
);

// ===== verif/led_panel.sv
`timescale 1ns/1ps
// Front panel; pull resistors set released pin levels
module led_panel (
  input  wire logic [6:0] strap,
  input  wire logic [6:0] pin_out,
  input  wire logic [6:0] pin_oe,
  output logic      [6:0] pin_level
);
  // Unknown enable counts as released
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pin_level[i] = (pin_oe[i] === 1'b1) ? pin_out[i] : strap[i];
    end
  end
endmodule

// ===== verif/test_led_power_ctrl.sv
`timescale 1ns/1ps
module test_led_power_ctrl;
  import led_pwr_pkg::*;
  localparam int UL = 200, BL = 8, TL = 16;
  localparam logic [13:0] PINS = 14'h007F, PATH = 14'h0180, UNP = 14'h0600;
  localparam logic [13:0] RXC = 14'h1800, CORE = 14'h2000;

  logic         aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic         s_axi_arvalid = 0, s_axi_rready = 0, snap = 0, clr = 0, use_seen = 0;
  logic         rx_dv_core = 0, rx_idle_core = 1, line_energy = 1;
  logic [11:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]  s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]   s_axi_wstrb = 4'hF;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic         ten_path_en, hundred_path_en, tx_full_drive, link_pulse_only;
  logic         core_enable, rx_clk_en, rx_dv;
  port_status_s port_status = '0, p;
  activity_s    activity = '0;
  logic [6:0]   strap, led_pin_in, led_pin_out, led_pin_oe, seen = '0, last, idx;
  logic [13:0]  w;
  logic [27:0]  e;
  logic [33:0]  rq[$];
  logic [1:0]   bq[$];
  logic [27:0]  pq[$];
  int           fails = 0, checks_done = 0, cyc = 0, n;
  wire  [13:0]  watch = {core_enable, rx_dv, rx_clk_en, link_pulse_only, tx_full_drive,
                         ten_path_en, hundred_path_en, use_seen ? seen : led_pin_out};

  always #25 aclk = ~aclk;

  led_panel i_panel (.strap, .pin_out(led_pin_out), .pin_oe(led_pin_oe),
                     .pin_level(led_pin_in));
  led_power_ctrl #(.UNPLUG_LIMIT(UL), .BLINK_LIMIT(BL), .TAIL_LIMIT(TL)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_status, .activity, .rx_dv_core, .rx_idle_core, .line_energy, .led_pin_in,
    .led_pin_out, .led_pin_oe, .ten_path_en, .hundred_path_en, .tx_full_drive,
    .link_pulse_only, .core_enable, .rx_clk_en, .rx_dv
  );

  // ------------------
  // Helpers
  // ------------------
  task check(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Steady outputs: standard is on XOR strap, advanced plain on
  function automatic logic [13:0] exp_w(port_status_s q, logic adv);
    logic [6:0] on;
    on = adv ? 7'(1 << {q.speed_100, q.full_duplex})
             : {3'b000, q.full_duplex, 1'b1, !q.speed_100, q.speed_100};
    if (!q.link) on = '0;
    return {1'b1, 4'h0, !q.speed_100, q.speed_100, adv ? on : on ^ strap};
  endfunction

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask

  task rd(input logic [11:0] a, input logic [33:0] x);
    @(posedge aclk);
    rq.push_back(x);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask

  // Snapshot after one edge so inputs have landed
  task chk(input logic [13:0] m, input logic [13:0] x);
    @(posedge aclk);
    pq.push_back({m, x});
    snap <= 1;
    @(posedge aclk);
    snap <= 0;
  endtask

  // Burst: m = pins that must toggle, r = resting levels
  task blink(input activity_s a, input logic [6:0] m, input logic [13:0] r);
    @(posedge aclk);
    activity <= a;
    clr <= 1;
    @(posedge aclk);
    clr <= 0;
    repeat (6 * BL) @(posedge aclk);
    use_seen <= 1;
    chk(PINS, 14'(m));
    activity <= '0;
    use_seen <= 0;
    repeat (3 * BL) @(posedge aclk);
    chk(PINS, r);
  endtask

  // ------------------
  // Result watcher and timeout
  // ------------------
  always @(posedge aclk) begin
    last <= led_pin_out;
    seen <= clr ? '0 : seen | (led_pin_out ^ last);
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(bq.pop_front()));
    if (snap) begin
      e = pq.pop_front();
      check(34'(watch & e[27:14]), 34'(e[13:0] & e[27:14]));
    end
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end

  // ------------------
  // Scenarios
  // ------------------
  initial begin
    n = $urandom(32'hC65E);
    strap = 7'($urandom);
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    rd(STRAP_OFFSET, {RESP_OKAY, 25'h0, strap});
    rd(CONTROL_OFFSET, {RESP_OKAY, CONTROL_RESET});
    rd(12'h010, {RESP_SLVERR, 32'h0});
    wr(12'h010, 32'hFFFF_FFFF, RESP_SLVERR);
    for (int s = 0; s < 2; s++) begin
      wr(MISC_OFFSET, 32'(s) << ADV_SCHEME_BIT, RESP_OKAY);
      for (int k = 0; k < 5; k++) begin
        p = (k == 4) ? 3'b000 : {1'b1, 2'(k)};
        port_status <= p;
        w = exp_w(p, s[0]);
        idx = 7'(1 << {p.speed_100, p.full_duplex});
        chk(PINS | PATH | CORE, w);
        if (p.link) begin
          blink(3'b100, s[0] ? (p.full_duplex ? 7'h00 : idx) : 7'h10, w);
          blink(3'b010, s[0] ? idx : 7'h20, w);
          if (!s[0] && !p.full_duplex) blink(3'b001, 7'h70, w);
        end
      end
    end
    // Power-down keeps only register access alive
    wr(MISC_OFFSET, 32'h0, RESP_OKAY);
    p = 3'b111;
    port_status <= p;
    wr(CONTROL_OFFSET, 32'h1 << POWER_DOWN_BIT, RESP_OKAY);
    chk(PINS | PATH | RXC | CORE, {7'h00, strap});
    rd(STATUS_OFFSET, {RESP_OKAY, 32'h0000_0027});
    wr(CONTROL_OFFSET, 32'h0, RESP_OKAY);
    // Quiet line reduces drive, energy restores it
    line_energy <= 0;
    repeat (UL - 20) @(posedge aclk);
    chk(UNP, 14'h0200);
    repeat (30) @(posedge aclk);
    chk(UNP, 14'h0400);
    line_energy <= 1;
    repeat (3) @(posedge aclk);
    chk(UNP, 14'h0200);
    // Idle wire with a frame of random length
    wr(MISC_OFFSET, 32'h1 << IDLE_WIRE_BIT, RESP_OKAY);
    rd(MISC_OFFSET, {RESP_OKAY, 32'h1});
    repeat (TL + 4) @(posedge aclk);
    chk(RXC, 14'h0000);
    rx_dv_core <= 1;
    rx_idle_core <= 0;
    chk(RXC, 14'h0800);
    n = 5 + $urandom % 10;
    repeat (n) @(posedge aclk);
    chk(RXC, 14'h1800);
    rx_dv_core <= 0;
    rx_idle_core <= 1;
    repeat (TL - 6) @(posedge aclk);
    chk(RXC, 14'h0800);
    repeat (10) @(posedge aclk);
    chk(RXC, 14'h0000);
    finish_test;
  end
endmodule
